//--- design/rcs_top.sv
// Purpose: Command origin selection and local/remote arbitration for a drive
// Assumes: Inputs synchronous to clk_in; APB registers; one clock
// Notes:   Keypad, serial and terminal origins meet here; fault flag is retained externally
//
// The implementer's own choices: the register offsets and the APB slave port.
`include "rcs_defines.svh"
`default_nettype none

module rcs_top
    import rcs_pkg::*;
#(
    parameter int BLINK_BITS = 24
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // APB slave
    input  wire rcs_pkg::rcs_apb_req_s apb_in,
    output logic                   pready_out,
    output logic [31:0]            prdata_out,
    output logic                   pslverr_out,
    // Terminals, keypad, serial link
    input  wire logic [6:0]        px_in,
    input  wire logic [4:0]        key_in,
    input  wire logic [2:0]        com_in,
    input  wire logic              fault_reset_seen_in,
    // Drive command and indicator
    output rcs_pkg::rcs_drive_s    drive_out,
    output logic                   set_indicator_out,
    output logic                   remote_out
);
    import rcs_pkg::*;

    rcs_state_s           st;
    rcs_state_s           next_st;
    logic [BLINK_BITS-1:0] blink_cnt;
    logic                 strap_done;

    // Terminal role mask for one function code
    function automatic logic [6:0] role_mask(input logic [41:0] defs, input logic [5:0] code);
        logic [6:0] m;
        m = '0;
        for (int i = 0; i < 7; i++) begin
            m[i] = (defs[i*6 +: 6] == code);
        end
        return m;
    endfunction

    logic [6:0] m_fwd, m_rev, m_perm, m_hold;
    logic       t_fwd, t_rev, t_perm, t_any_cmd, t_all_off, t_rise;
    logic       esc_press, wr, rd, esc_wr_toggle;
    logic [1:0] wr_esc;
    rcs_drive_s want;

    // Terminal decode
    always_comb begin
        m_fwd     = role_mask(st.pxdef, `RCS_FN_FWD);
        m_rev     = role_mask(st.pxdef, `RCS_FN_REV);
        m_perm    = role_mask(st.pxdef, `RCS_FN_PERMIT);
        m_hold    = m_fwd | m_rev | role_mask(st.pxdef, `RCS_FN_JOGF)
                  | role_mask(st.pxdef, `RCS_FN_JOGR) | role_mask(st.pxdef, `RCS_FN_PREEX);
        t_fwd     = |(px_in & m_fwd);
        t_rev     = |(px_in & m_rev);
        t_perm    = |(px_in & m_perm);
        t_any_cmd = |(px_in & m_hold);
        t_all_off = (px_in == 7'h00);
        t_rise    = |(px_in & ~st.px_prev & m_hold);
        esc_press = key_in[`RCS_KEY_ESC_BIT] & ~st.esc_prev;
        wr        = apb_in.psel & apb_in.penable & apb_in.pwrite;
        rd        = apb_in.psel & ~apb_in.pwrite;
        wr_esc    = apb_in.pwdata[`RCS_CFG_ESC_LSB +: 2];
        esc_wr_toggle = wr && (apb_in.paddr == `RCS_CFG_OFS) && (wr_esc == `RCS_ESC_LOCREM)
                      && (st.esc_fn != `RCS_ESC_LOCREM);
    end

    // Next state
    always_comb begin
        next_st         = st;
        next_st.px_prev = px_in;
        next_st.esc_prev = key_in[`RCS_KEY_ESC_BIT];
        next_st.pready  = apb_in.psel & ~apb_in.penable;
        next_st.pslverr = 1'b0;
        // Keypad run/stop latch
        if (key_in[`RCS_KEY_STOP_BIT]) begin
            next_st.key_run = 1'b0;
        end else if (key_in[`RCS_KEY_RUN_BIT]) begin
            next_st.key_run = 1'b1;
        end
        next_st.key_rev = key_in[`RCS_KEY_REV_BIT];
        // Serial run/stop latch
        if (com_in[`RCS_COM_STOP_BIT]) begin
            next_st.com_run = 1'b0;
        end else if (com_in[`RCS_COM_RUN_BIT]) begin
            next_st.com_run = 1'b1;
        end
        next_st.com_rev = com_in[`RCS_COM_REV_BIT];
        // Terminal interlock: arm only on a fresh rising edge; all released clears post fault
        if (st.post_fault) begin
            if (t_all_off) begin
                next_st.post_fault = 1'b0;
            end
        end else if (!st.term_armed && (t_rise || (!t_any_cmd && !st.autostart))) begin
            next_st.term_armed = t_rise;
        end
        // Local/remote toggling by the escape key
        if (esc_press && st.esc_fn == `RCS_ESC_LOCREM) begin
            next_st.remote = ~st.remote;
            if (st.remote) begin
                next_st.key_run = 1'b0;
            end else begin
                // Digital origins restart only on their next command
                next_st.com_run = 1'b0;
                next_st.key_run = 1'b0;
                if (st.post_fault) begin
                    next_st.term_armed = 1'b0;
                end
            end
        end
        if (esc_wr_toggle) begin
            next_st.remote = 1'b1;
        end
        // Register writes; mode change never touches these
        if (wr) begin
            unique case (apb_in.paddr)
                `RCS_CFG_OFS: begin
                    next_st.src       = apb_in.pwdata[`RCS_CFG_SRC_LSB +: 3];
                    next_st.esc_fn    = wr_esc;
                    next_st.autostart = apb_in.pwdata[`RCS_CFG_AUTO_BIT];
                end
                `RCS_PXDEF_OFS: next_st.pxdef[31:0] = apb_in.pwdata;
                `RCS_KEYCMD_OFS: next_st.pxdef[41:32] = apb_in.pwdata[9:0];
                default: next_st.pslverr = (apb_in.paddr > `RCS_STATUS_OFS) & st.pready;
            endcase
        end
        if (apb_in.psel && !apb_in.penable && apb_in.paddr > `RCS_STATUS_OFS) begin
            next_st.pslverr = 1'b1;
        end
        // Read data
        if (rd) begin
            unique case (apb_in.paddr)
                `RCS_CFG_OFS:    next_st.prdata = {23'h0, st.autostart, 2'h0, st.esc_fn,
                                                   1'h0, st.src};
                `RCS_PXDEF_OFS:  next_st.prdata = st.pxdef[31:0];
                `RCS_KEYCMD_OFS: next_st.prdata = {22'h0, st.pxdef[41:32]};
                `RCS_STATUS_OFS: next_st.prdata = {26'h0, st.post_fault, st.term_armed,
                                                   st.remote, st.drive};
                default:         next_st.prdata = 32'h0;
            endcase
        end
        // Command arbitration
        want = '0;
        if (!st.remote) begin
            want.run     = st.key_run;
            want.reverse = st.key_rev;
            want.jog     = key_in[`RCS_KEY_JOG_BIT] & t_perm;
        end else begin
            unique case (st.src)
                `RCS_SRC_KEYPAD: begin
                    want.run     = st.key_run;
                    want.reverse = st.key_rev;
                end
                `RCS_SRC_PAIR: begin
                    want.run     = (t_fwd ^ t_rev) & st.term_armed & ~st.post_fault;
                    want.reverse = t_rev;
                end
                `RCS_SRC_RUNDIR: begin
                    // Direction tracks the terminal even while the run is not armed
                    want.run     = t_fwd & st.term_armed & ~st.post_fault;
                    want.reverse = t_rev;
                end
                `RCS_SRC_SERIAL: begin
                    want.run     = st.com_run;
                    want.reverse = st.com_rev;
                end
                default: want = '0;
            endcase
        end
        next_st.drive     = want;
        next_st.blink     = blink_cnt[BLINK_BITS-1];
        next_st.indicator = ~st.remote & st.blink;
    end

    // Registered state and flash divider
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st            <= '0;
            st.remote     <= 1'b1;
            st.pxdef      <= `RCS_PXDEF_RST;
            blink_cnt     <= '0;
            strap_done    <= 1'b0;
        end else begin
            st         <= next_st;
            blink_cnt  <= blink_cnt + 1'b1;
            strap_done <= 1'b1;
            // Power-up mode caught after reset release
            if (!strap_done) begin
                st.remote     <= ~fault_reset_seen_in;
                st.post_fault <= fault_reset_seen_in;
                st.term_armed <= 1'b0;
            end
        end
    end

    assign pready_out        = st.pready;
    assign prdata_out        = st.prdata;
    assign pslverr_out       = st.pslverr;
    assign drive_out         = st.drive;
    assign set_indicator_out = st.indicator;
    assign remote_out        = st.remote;

    // Checks
    property p_local_flash;
        @(posedge clk_in) disable iff (rst_in)
        (!st.remote && !$past(st.remote)) |-> (set_indicator_out == $past(st.blink));
    endproperty
    a_local_flash: assert property (p_local_flash) else $error("indicator wrong in local");

    property p_remote_dark;
        @(posedge clk_in) disable iff (rst_in)
        (st.remote && $past(st.remote)) |-> !set_indicator_out;
    endproperty
    a_remote_dark: assert property (p_remote_dark) else $error("indicator lit in remote");

    property p_esc_gated;
        @(posedge clk_in) disable iff (rst_in)
        (esc_press && st.esc_fn != `RCS_ESC_LOCREM && !esc_wr_toggle && strap_done)
            |=> (st.remote == $past(st.remote));
    endproperty
    a_esc_gated: assert property (p_esc_gated) else $error("mode changed without toggle");

    property p_rundir;
        @(posedge clk_in) disable iff (rst_in)
        (st.remote && st.src == `RCS_SRC_RUNDIR && !esc_press && strap_done)
            |=> (drive_out.reverse == $past(t_rev));
    endproperty
    a_rundir: assert property (p_rundir) else $error("direction not from reverse input");

    property p_pair_stop;
        @(posedge clk_in) disable iff (rst_in)
        (st.remote && st.src == `RCS_SRC_PAIR && t_fwd == t_rev) |=> !drive_out.run;
    endproperty
    a_pair_stop: assert property (p_pair_stop) else $error("pair mode ran on equal inputs");

    property p_jog_permit;
        @(posedge clk_in) disable iff (rst_in)
        (!st.remote && !t_perm) |=> !drive_out.jog;
    endproperty
    a_jog_permit: assert property (p_jog_permit) else $error("jog without permit");

    property p_no_autostart;
        @(posedge clk_in) disable iff (rst_in)
        (!st.term_armed && st.remote && st.src == `RCS_SRC_RUNDIR) |=> !drive_out.run;
    endproperty
    a_no_autostart: assert property (p_no_autostart) else $error("unarmed terminal run");

    property p_local_stop;
        @(posedge clk_in) disable iff (rst_in)
        (esc_press && st.remote && st.esc_fn == `RCS_ESC_LOCREM) |=> ##1 !drive_out.run;
    endproperty
    a_local_stop: assert property (p_local_stop) else $error("run kept after going local");
endmodule
`default_nettype wire

//--- pkg/rcs_defines.svh
// Purpose: Offsets, fields, reset values and codes for the command source selector
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// Register byte offsets
`define RCS_CFG_OFS        12'h000
`define RCS_PXDEF_OFS      12'h004
`define RCS_KEYCMD_OFS     12'h008
`define RCS_COMCMD_OFS     12'h00c
`define RCS_STATUS_OFS     12'h010

// Configuration fields
`define RCS_CFG_SRC_LSB    0
`define RCS_CFG_ESC_LSB    4
`define RCS_CFG_AUTO_BIT   8
`define RCS_CFG_RST        32'h0000_0000

// Command origin codes
`define RCS_SRC_KEYPAD     3'h0
`define RCS_SRC_PAIR       3'h1
`define RCS_SRC_RUNDIR     3'h2
`define RCS_SRC_SERIAL     3'h3

// Escape key function code for local/remote toggling
`define RCS_ESC_LOCREM     2'h2

// Terminal function codes
`define RCS_FN_FWD         6'h01
`define RCS_FN_REV         6'h02
`define RCS_FN_PERMIT      6'h0d
`define RCS_FN_JOGF        6'h04
`define RCS_FN_JOGR        6'h05
`define RCS_FN_PREEX       6'h06

// Keypad and serial command bits
`define RCS_KEY_RUN_BIT    0
`define RCS_KEY_STOP_BIT   1
`define RCS_KEY_ESC_BIT    2
`define RCS_KEY_REV_BIT    3
`define RCS_KEY_JOG_BIT    4
`define RCS_COM_RUN_BIT    0
`define RCS_COM_STOP_BIT   1
`define RCS_COM_REV_BIT    2

// Function codes of all seven terminals, 6 bits each
`define RCS_PXDEF_RST      42'h0

`endif

//--- pkg/rcs_pkg.sv
// Purpose: Types for the command source selector
// Assumes: Constants come from rcs_defines.svh
// Notes:   State is one packed struct
`default_nettype none
package rcs_pkg;
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rcs_apb_req_s;

    // Drive command to the motor control
    typedef struct packed {
        logic run;
        logic reverse;
        logic jog;
    } rcs_drive_s;

    // Whole block state
    typedef struct packed {
        logic [2:0]  src;
        logic [1:0]  esc_fn;
        logic        autostart;
        logic [41:0] pxdef;
        logic        remote;
        logic        blink;
        logic        key_run;
        logic        com_run;
        logic        com_rev;
        logic        key_rev;
        logic        term_armed;
        logic        post_fault;
        logic [6:0]  px_prev;
        logic        esc_prev;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        rcs_drive_s  drive;
        logic        indicator;
    } rcs_state_s;
endpackage
`default_nettype wire

//--- verification/rcs_switch_model.sv
// Purpose: Terminal switch bank on the far side of the selector
// Assumes: Switches change only after a clock edge
// Notes:   Lag of one or four cycles mimics prompt or slow contacts
`default_nettype none
module rcs_switch_model (
    // Clock and requested switch levels
    input  wire logic       clk_in,
    input  wire logic [6:0] want_in,
    input  wire logic       slow_in,
    // Terminal levels towards the device
    output logic [6:0]      px_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] pipe [4] = '{default: 7'h00};

    // Delay line for the contact lag
    always @(posedge clk_in) begin
        pipe[0] <= want_in;
        for (int i = 1; i < 4; i++) begin
            pipe[i] <= pipe[i-1];
        end
    end

    // Selected lag
    assign px_out = slow_in ? pipe[3] : pipe[0];
endmodule
`default_nettype wire

//--- verification/rcs_top_bench.sv
// Purpose: Self-checking bench for the command source selector
// Assumes: APB master and a behavioural reference model
// Notes:   Small flash divider keeps runs short
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rcs_top_bench import rcs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_in = 1'b0;
    logic         rst_in = 1'b1;
    rcs_apb_req_s apb = '0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    logic [6:0]   px;
    logic [6:0]   want = 7'h01;
    logic         slow = 1'b0;
    logic [4:0]   key = 5'h00;
    logic [2:0]   com = 3'h0;
    logic         fault = 1'b0;
    rcs_drive_s   drive;
    logic         ind;
    logic         remote;
    int           mismatches = 0;
    int           tests_run = 0;
    int           seed = 27;
    int           m_src, m_esc;
    logic         m_remote, m_armed, m_key, m_com;
    logic [6:0]   m_px = 7'h01;
    logic [31:0]  d;
    logic         e;

    // Clock
    always #4 clk_in = ~clk_in;

    rcs_switch_model i_sw (.clk_in(clk_in), .want_in(want), .slow_in(slow), .px_out(px));
    rcs_top #(.BLINK_BITS(4)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .px_in(px),
        .key_in(key), .com_in(com), .fault_reset_seen_in(fault), .drive_out(drive),
        .set_indicator_out(ind), .remote_out(remote));

    // Reference model of run and direction
    function automatic logic [1:0] model();
        if (!m_remote) return {m_key, 1'b0};
        case (m_src)
            0: return {m_key, 1'b0};
            1: return {m_armed & (m_px[0] ^ m_px[1]), m_px[1]};
            2: return {m_armed & m_px[0], m_px[1]};
            default: return {m_com, 1'b0};
        endcase
    endfunction

    // Compare drive and mode with the model
    task automatic check();
        logic [1:0] x;
        @(negedge clk_in);
        x = model();
        `CHK({drive.run, drive.run & drive.reverse, drive.jog}, {x[1], &x, 1'b0})
        `CHK(remote, m_remote)
    endtask

    // One APB transfer, waits for pready
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        apb <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_in);
        end
        if (n == 50) begin
            mismatches++;
            complete_run();
        end
        d = prdata;
        e = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // Configuration write with model update
    task automatic cfg(input int s, input int es);
        apb_xfer(1'b1, 12'h000, 32'(s) | (32'(es) << 4));
        if (es == 2 && m_esc != 2 && !m_remote) begin
            m_remote = 1'b1;
            m_key = 1'b0;
        end
        m_src = s;
        m_esc = es;
        repeat (4) @(posedge clk_in);
        check();
    endtask

    // Terminal change through the switch bank
    task automatic set_px(input logic [1:0] p);
        m_armed |= |(p & ~m_px[1:0]);
        m_px[1:0] = p;
        @(posedge clk_in);
        want <= {5'($random(seed)), p};
        slow <= ~slow;
        repeat (9) @(posedge clk_in);
        check();
    endtask

    // Key or serial pulse: 0 run, 1 stop, 2 escape on the keypad
    task automatic press(input int b, input logic serial);
        @(posedge clk_in);
        if (serial) com <= 3'(1 << b);
        else key <= 5'(1 << b);
        repeat (2) @(posedge clk_in);
        key <= 5'h00;
        com <= 3'h0;
        if (serial) m_com = (b == 0);
        else if (b < 2) m_key = (b == 0);
        else if (m_esc == 2) begin
            m_remote = ~m_remote;
            m_key = 1'b0;
            m_com = 1'b0;
        end
        repeat (5) @(posedge clk_in);
        check();
    endtask

    // Flash watch over several divider periods
    task automatic blink(input logic flash);
        int hi;
        hi = 0;
        repeat (40) begin
            @(negedge clk_in);
            if (ind === 1'b1) hi++;
        end
        `CHK(hi > 0 && hi < 40, flash)
        $display("test blink end");
    endtask

    task automatic do_reset(input logic f);
        @(posedge clk_in);
        fault <= f;
        rst_in <= 1'b1;
        @(negedge clk_in);
        `CHK(remote, 1'b1)
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        {m_src, m_esc, m_armed, m_key, m_com} = '0;
        m_remote = ~f;
        repeat (3) @(posedge clk_in);
        check();
        $display("test reset end");
    endtask

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200us;
        mismatches++;
        complete_run();
    end

    // Main sequence
    initial begin
        do_reset(1'b0);
        apb_xfer(1'b0, 12'h014, 32'h0);
        `CHK(e, 1'b1)
        apb_xfer(1'b1, 12'h004, 32'h0000_0081);
        apb_xfer(1'b1, 12'h008, 32'h0000_0000);
        cfg(2, 2);
        set_px(2'h0);
        set_px(2'h1);
        set_px(2'h3);
        press(2, 1'b0);
        blink(1'b1);
        press(0, 1'b0);
        press(1, 1'b0);
        press(0, 1'b0);
        press(2, 1'b0);
        blink(1'b0);
        apb_xfer(1'b0, 12'h000, 32'h0);
        `CHK(d, 32'h0000_0022)
        apb_xfer(1'b0, 12'h004, 32'h0);
        `CHK(d, 32'h0000_0081)
        cfg(1, 2);
        for (int i = 0; i < 4; i++) set_px(2'(i));
        set_px(2'h0);
        cfg(3, 2);
        press(0, 1'b1);
        press(1, 1'b1);
        cfg(0, 2);
        press(0, 1'b0);
        press(1, 1'b0);
        press(2, 1'b0);
        cfg(0, 0);
        press(2, 1'b0);
        cfg(0, 2);
        $display("test modes end");
        do_reset(1'b1);
        press(0, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
